// ### logic/cfg_pkg.sv
`default_nettype none
package cfg_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_CONFIG = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK = 4'h8;
    // Configuration field positions
    localparam int BIT_BIG_ENDIAN = 0;
    localparam int BIT_RESERVED1 = 1;
    localparam int BIT_BOOT_ROM_DIS = 2;
    localparam int BIT_PARITY_ACT = 3;
    localparam int BIT_DEFER_DIS = 4;
    localparam int BIT_COLL_START = 5;
    localparam int BIT_SINGLE_BO = 6;
    localparam int BIT_REQ_POLICY = 7;
    localparam int BIT_LEGACY_DESC = 8;
    localparam int BIT_XCVR_DIS = 9;
    localparam int BIT_XCVR_RST = 10;
    localparam int BIT_EXT_XCVR = 12;
    // Writable configuration bits and reset value
    localparam logic [31:0] CONFIG_WMASK = 32'h000017FD;
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;
    // Status event bit positions
    localparam int EV_SERR = 0;
    localparam int EV_DEFER = 1;
    localparam int EV_XCVR_RST = 2;
    localparam int EV_W = 3;
    // Descriptor word counts
    localparam logic [2:0] DESC_WORDS_LEGACY = 3'h4;
    localparam logic [2:0] DESC_WORDS_NEW = 3'h3;
    // Collision slot length in bit times
    localparam logic [9:0] SLOT_BITS = 10'h200;
    // Request-policy idle gap in clocks for the conservative scheme
    localparam logic [3:0] REQ_GAP = 4'h4;
endpackage
`default_nettype wire

// ### logic/byte_swap.sv
`timescale 1ns/10ps
`default_nettype none
// Optional byte reversal on the bus-master data path
module byte_swap (
    // Control
    input wire logic swap_in,
    // Data
    input wire logic [31:0] data_in,
    output logic [31:0] data_out
);
    wire [31:0] swapped = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
    assign data_out = swap_in ? swapped : data_in;
endmodule
`default_nettype wire

// ### logic/slot_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Out-of-window collision timer, counts one slot of bit times
module slot_timer
    import cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Frame progress
    input wire logic start_in,
    input wire logic bit_tick_in,
    // Timer state
    output logic running_out,
    output logic expired_out
);
    logic [9:0] count; // Bit times remaining
    // Load on start, count down one bit per tick
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            count <= 10'h000;
            expired_out <= 1'b0;
        end else if (start_in) begin
            count <= SLOT_BITS;
            expired_out <= 1'b0;
        end else if (bit_tick_in && count != 10'h000) begin
            count <= count - 10'h001;
            expired_out <= (count == 10'h001);
        end else begin
            expired_out <= 1'b0;
        end
    end
    assign running_out = (count != 10'h000);
endmodule
`default_nettype wire

// ### logic/dev_config.sv
`timescale 1ns/10ps
`default_nettype none
module dev_config
    import cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Interrupt
    output logic irq_out,
    // Transceiver control
    output logic xcvr_reset_out,
    output logic xcvr_power_down_out,
    output logic mii_enable_out,
    // Descriptor fetch
    output logic [2:0] desc_words_out,
    output logic frag_count_ignore_out,
    // Bus request
    input wire logic req_want_in,
    output logic bus_req_out,
    // Transmit MAC
    output logic single_backoff_out,
    input wire logic tx_preamble_first_in,
    input wire logic tx_sfd_done_in,
    input wire logic tx_bit_tick_in,
    output logic coll_window_open_out,
    input wire logic tx_defer_expired_in,
    output logic excessive_deferral_status_out,
    output logic tx_deferral_inc_out,
    // System error path
    input wire logic master_parity_err_in,
    output logic serr_out,
    // Boot ROM interface
    input wire logic rom_req_in,
    output logic rom_enable_out,
    // Bus-master data path
    input wire logic [31:0] master_data_in,
    output logic [31:0] master_data_out
);
    // Stored configuration and interrupt registers
    logic [31:0] device_configuration;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [3:0] gap_count; // Idle clocks since last request in conservative mode

    // Merge byte lanes into an old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Decode
    wire sel_config = (avs_address_in == OFF_CONFIG);
    wire sel_status = (avs_address_in == OFF_STATUS);
    wire sel_mask = (avs_address_in == OFF_MASK);
    // Waitrequest high with a strobe marks the first clock of an access
    wire req_first = avs_waitrequest_out && (avs_read_in || avs_write_in);
    // Writes land only at the edge that ends the wait
    wire wr_accept = avs_write_in && !avs_waitrequest_out;
    wire wr_config = wr_accept && sel_config;
    wire wr_mask = wr_accept && sel_mask;
    // Read side effects happen once, in the clock that latches the data
    wire rd_first = avs_read_in && avs_waitrequest_out;
    wire rd_status = rd_first && sel_status;

    // Next configuration: reserved bit held zero, external select forces disable
    // Hazard: bit 9 can only be cleared by a write that also clears bit 12
    wire [31:0] merged = lane_merge(device_configuration, avs_writedata_in, avs_byteenable_in);
    wire [31:0] masked = merged & CONFIG_WMASK;
    wire [31:0] next_config = masked | (32'(masked[BIT_EXT_XCVR]) << BIT_XCVR_DIS);

    // Field views
    wire cfg_big_endian = device_configuration[BIT_BIG_ENDIAN];
    wire cfg_rom_dis = device_configuration[BIT_BOOT_ROM_DIS];
    wire cfg_parity_act = device_configuration[BIT_PARITY_ACT];
    wire cfg_defer_dis = device_configuration[BIT_DEFER_DIS];
    wire cfg_coll_start = device_configuration[BIT_COLL_START];
    wire cfg_req_policy = device_configuration[BIT_REQ_POLICY];

    // Events that hardware raises
    // Parity error on a master cycle, dropped when software recovers itself
    wire ev_serr = master_parity_err_in && !cfg_parity_act;
    // Deferral timeout, dropped entirely while the timer is disabled
    wire ev_defer = tx_defer_expired_in && !cfg_defer_dis;
    // Software has just put the transceiver into reset
    wire ev_rst = wr_config && next_config[BIT_XCVR_RST] && !device_configuration[BIT_XCVR_RST];
    wire [EV_W-1:0] events = {ev_rst, ev_defer, ev_serr};
    // Set wins over the read-clear
    wire [EV_W-1:0] next_status = (rd_status ? {EV_W{1'b0}} : status) | events;

    // Read mux; register space never swapped
    // Unmapped offsets read zero
    wire [31:0] rd_mux = sel_config ? device_configuration :
                         sel_status ? {{(32-EV_W){1'b0}}, status} :
                         sel_mask ? {{(32-EV_W){1'b0}}, mask} : 32'h00000000;

    // Conservative request scheme: wait REQ_GAP clocks after a drop
    // Aggressive mode asks again at once
    wire req_allow = !cfg_req_policy || (gap_count >= REQ_GAP);

    // Collision timer start point
    wire coll_start = cfg_coll_start ? tx_preamble_first_in : tx_sfd_done_in;
    wire coll_running;

    // Master data byte order
    wire [31:0] swapped_data;

    // The timer restarts on every start strobe; a second start within a
    // frame simply reopens the window
    slot_timer u_slot (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(coll_start),
        .bit_tick_in(tx_bit_tick_in),
        .running_out(coll_running),
        .expired_out()
    );

    // Only master data is reordered; the register path bypasses this
    byte_swap u_swap (
        .swap_in(cfg_big_endian),
        .data_in(master_data_in),
        .data_out(swapped_data)
    );

    // Configuration, mask and status registers
    // Writes take effect only at the edge that ends the wait
    // Status is written every clock so that events are never lost
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            device_configuration <= CONFIG_RESET;
            mask <= {EV_W{1'b0}};
            status <= {EV_W{1'b0}};
        end else begin
            if (wr_config) begin
                device_configuration <= next_config;
            end
            if (wr_mask) begin
                mask <= avs_writedata_in[EV_W-1:0];
            end
            status <= next_status;
        end
    end

    // Every access waits one clock; read data is latched in that first clock
    // Waitrequest idles high so it can come straight from a flop; the price
    // is one extra clock on every write
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1; // Stalls anything issued during reset
            avs_readdata_out <= 32'h00000000;
        end else begin
            avs_waitrequest_out <= !req_first;
            if (rd_first) begin
                avs_readdata_out <= rd_mux; // Holds until the next read
            end
        end
    end

    // Request gap counter
    // Counts idle clocks since the request dropped and saturates, so a long
    // idle period never wraps round into a short one
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gap_count <= 4'h0;
        end else if (bus_req_out) begin
            gap_count <= 4'h0;
        end else if (gap_count != 4'hF) begin
            gap_count <= gap_count + 4'h1;
        end
    end

    // Registered control outputs
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
            xcvr_reset_out <= 1'b0;
            xcvr_power_down_out <= 1'b0;
            mii_enable_out <= 1'b0;
            desc_words_out <= DESC_WORDS_NEW;
            frag_count_ignore_out <= 1'b0;
            bus_req_out <= 1'b0;
            single_backoff_out <= 1'b0;
            coll_window_open_out <= 1'b0;
            excessive_deferral_status_out <= 1'b0;
            tx_deferral_inc_out <= 1'b0;
            serr_out <= 1'b0;
            rom_enable_out <= 1'b0;
            master_data_out <= 32'h00000000;
        end else begin
            // Interrupt level from the status that this edge stores
            irq_out <= |(next_status & mask);
            // Transceiver controls follow the stored bits one clock late
            xcvr_reset_out <= device_configuration[BIT_XCVR_RST];
            xcvr_power_down_out <= device_configuration[BIT_XCVR_DIS];
            mii_enable_out <= device_configuration[BIT_EXT_XCVR];
            // Descriptor format for the fetch engine
            desc_words_out <= device_configuration[BIT_LEGACY_DESC] ? DESC_WORDS_LEGACY
                                                                   : DESC_WORDS_NEW;
            frag_count_ignore_out <= device_configuration[BIT_LEGACY_DESC];
            // Once granted, a request is held while still wanted
            bus_req_out <= req_want_in && (bus_req_out || req_allow);
            // Transmit MAC controls
            single_backoff_out <= device_configuration[BIT_SINGLE_BO];
            coll_window_open_out <= coll_running;
            // Deferral status is sticky; a new event beats the read-clear
            if (ev_defer) begin
                excessive_deferral_status_out <= 1'b1;
            end else if (rd_status) begin
                excessive_deferral_status_out <= 1'b0;
            end
            tx_deferral_inc_out <= ev_defer;
            // System error follows the gated parity error, one clock late
            serr_out <= ev_serr;
            // Boot ROM strobe passes only while the interface is enabled
            rom_enable_out <= rom_req_in && !cfg_rom_dis;
            // Master data in the selected byte order
            master_data_out <= swapped_data;
        end
    end

    // Checks: transceiver control
    a_xcvr_reset_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
        device_configuration[BIT_XCVR_RST] |=> xcvr_reset_out)
        else $error("transceiver reset not held");
    a_xcvr_reset_off: assert property (@(posedge mclk_in) disable iff (rst_in)
        !device_configuration[BIT_XCVR_RST] |=> !xcvr_reset_out)
        else $error("transceiver reset held while bit clear");
    a_xcvr_rst_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
        (device_configuration[BIT_XCVR_RST] && !wr_config) |=> device_configuration[BIT_XCVR_RST])
        else $error("transceiver reset bit cleared by hardware");
    a_power_down: assert property (@(posedge mclk_in) disable iff (rst_in)
        device_configuration[BIT_XCVR_DIS] |=> xcvr_power_down_out)
        else $error("power down not forced");
    a_power_up: assert property (@(posedge mclk_in) disable iff (rst_in)
        !device_configuration[BIT_XCVR_DIS] |=> !xcvr_power_down_out)
        else $error("power down without disable bit");
    // Checks: descriptor format
    a_desc_words: assert property (@(posedge mclk_in) disable iff (rst_in)
        ##1 desc_words_out == ($past(device_configuration[BIT_LEGACY_DESC]) ? 3'h4 : 3'h3))
        else $error("descriptor word count wrong");
    a_frag_ignore: assert property (@(posedge mclk_in) disable iff (rst_in)
        device_configuration[BIT_LEGACY_DESC] |=> frag_count_ignore_out)
        else $error("fragment count not ignored");
    a_desc_short: assert property (@(posedge mclk_in) disable iff (rst_in)
        !device_configuration[BIT_LEGACY_DESC]
            |=> (desc_words_out == DESC_WORDS_NEW) && !frag_count_ignore_out)
        else $error("short descriptor format wrong");
    // Checks: error paths and boot ROM
    a_serr_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
        serr_out |-> $past(master_parity_err_in) && !$past(cfg_parity_act))
        else $error("SERR without cause or while suppressed");
    a_serr_raise: assert property (@(posedge mclk_in) disable iff (rst_in)
        (master_parity_err_in && !cfg_parity_act) |=> serr_out)
        else $error("parity error did not raise SERR");
    a_defer_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
        (tx_defer_expired_in && cfg_defer_dis) |=> !tx_deferral_inc_out)
        else $error("deferral counted while disabled");
    a_defer_count: assert property (@(posedge mclk_in) disable iff (rst_in)
        (tx_defer_expired_in && !cfg_defer_dis)
            |=> tx_deferral_inc_out && excessive_deferral_status_out)
        else $error("deferral not reported");
    a_defer_status_off: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_defer_dis && !excessive_deferral_status_out) |=> !excessive_deferral_status_out)
        else $error("deferral status set while disabled");
    a_status_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        (status[EV_SERR] && !rd_status) |=> status[EV_SERR])
        else $error("status bit lost without a read");
    a_rom_inhibit: assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rom_dis |=> !rom_enable_out)
        else $error("boot ROM active while disabled");
    a_rom_pass: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rom_req_in && !cfg_rom_dis) |=> rom_enable_out)
        else $error("boot ROM request blocked");
    // Checks: data path and register bus
    a_big_endian: assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_big_endian |=> master_data_out[7:0] == $past(master_data_in[31:24]))
        else $error("master data not swapped");
    a_master_straight: assert property (@(posedge mclk_in) disable iff (rst_in)
        !cfg_big_endian |=> master_data_out == $past(master_data_in))
        else $error("master data reordered");
    a_reg_order: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rd_first && sel_config) |=> avs_readdata_out == $past(device_configuration))
        else $error("register read reordered");
    a_read_wait_one: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_first |=> !avs_waitrequest_out)
        else $error("read wait longer than one clock");
    // Checks: register contents
    a_ext_sets_dis: assert property (@(posedge mclk_in) disable iff (rst_in)
        device_configuration[BIT_EXT_XCVR] |-> device_configuration[BIT_XCVR_DIS])
        else $error("external select without disable");
    a_reserved_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        !device_configuration[BIT_RESERVED1])
        else $error("reserved bit set");
    a_write_lands: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_config |=> device_configuration == $past(next_config))
        else $error("configuration write lost");
    // Checks: bus request and transmit MAC
    a_conservative_gap: assert property (@(posedge mclk_in) disable iff (rst_in)
        ($fell(bus_req_out) && cfg_req_policy) |=> !bus_req_out [*3])
        else $error("conservative request gap too short");
    a_aggressive_req: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!cfg_req_policy && req_want_in) |=> bus_req_out)
        else $error("aggressive request delayed");
    a_single_bo: assert property (@(posedge mclk_in) disable iff (rst_in)
        ##1 single_backoff_out == $past(device_configuration[BIT_SINGLE_BO]))
        else $error("single backoff not driven");
    a_coll_start: assert property (@(posedge mclk_in) disable iff (rst_in)
        coll_start |=> ##1 coll_window_open_out)
        else $error("collision window not opened");
    // Main scenarios
    c_serr: cover property (@(posedge mclk_in) disable iff (rst_in) serr_out);
    c_irq: cover property (@(posedge mclk_in) disable iff (rst_in) irq_out);
    c_ext: cover property (@(posedge mclk_in) disable iff (rst_in) mii_enable_out);
    c_swap: cover property (@(posedge mclk_in) disable iff (rst_in)
        cfg_big_endian && avs_read_in && !avs_waitrequest_out);
    c_conservative: cover property (@(posedge mclk_in) disable iff (rst_in)
        $fell(bus_req_out) && cfg_req_policy);
endmodule
`default_nettype wire

// ### dv/mac_biu_config_low_bits_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Register-driven bench for the configuration bits block
module mac_biu_config_low_bits_tb
    import cfg_pkg::*;
();
    logic mclk, rst; // Clock and reset
    logic [3:0] addr, be; // Bus address and lanes
    logic rd, wr; // Bus strobes
    logic [31:0] wdata, rdata, rd_val; // Bus data, last read value
    logic wait_rq, irq, x_rst, x_pd, mii, frag_ign, bus_req, sbo, coll_open;
    logic def_stat, def_inc, serr, rom_en;
    logic [2:0] dwords; // Descriptor length
    logic req_want, pre_first, sfd_done, bit_tick, def_exp, perr, rom_req;
    logic [31:0] mdata_in, mdata_out; // Master data path
    int mismatches, n_tests; // Report counters

    dev_config i_dev_config (.mclk_in(mclk), .rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
        .irq_out(irq), .xcvr_reset_out(x_rst), .xcvr_power_down_out(x_pd),
        .mii_enable_out(mii), .desc_words_out(dwords), .frag_count_ignore_out(frag_ign),
        .req_want_in(req_want), .bus_req_out(bus_req), .single_backoff_out(sbo),
        .tx_preamble_first_in(pre_first), .tx_sfd_done_in(sfd_done),
        .tx_bit_tick_in(bit_tick), .coll_window_open_out(coll_open),
        .tx_defer_expired_in(def_exp), .excessive_deferral_status_out(def_stat),
        .tx_deferral_inc_out(def_inc), .master_parity_err_in(perr), .serr_out(serr),
        .rom_req_in(rom_req), .rom_enable_out(rom_en), .master_data_in(mdata_in),
        .master_data_out(mdata_out));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Verdict; the only place the run ends
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One comparison; four-state so an unknown never matches
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bus cycle: request right after an edge, held until waitrequest is low at an edge
    task automatic access(input logic is_wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= is_wr;
        rd <= !is_wr;
        @(posedge mclk);
        while (wait_rq !== 1'b0) begin
            n++;
            if (n > 20) begin
                mismatches++;
                $display("ERROR waitrequest expected 0 seen %b", wait_rq);
                end_of_test();
            end
            @(posedge mclk);
        end
        // Read data taken at the same edge that ends the wait
        rd_val = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // Extra edge so the next call never re-raises a strobe in the same step
        @(posedge mclk);
    endtask

    // Read and compare in one go
    task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h00000000);
        chk(what, rd_val, exp);
    endtask

    // Let registered outputs land, then stop mid-cycle for sampling
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // One-cycle event pulse; ends mid-cycle right after the pulse was taken
    task automatic kick(input int which);
        case (which)
            0: perr <= 1'b1;
            1: def_exp <= 1'b1;
            2: sfd_done <= 1'b1;
            default: pre_first <= 1'b1;
        endcase
        @(posedge mclk);
        {perr, def_exp, sfd_done, pre_first} <= 4'h0;
        @(negedge mclk);
    endtask

    // Main sequence
    initial begin
        mismatches = 0;
        n_tests = 0;
        {rst, rd, wr} = 3'h4;
        {addr, wdata, mdata_in} = '0;
        be = 4'hF; // All lanes unless a test narrows them
        {req_want, pre_first, sfd_done, bit_tick, def_exp, perr, rom_req} = 7'h00;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        look(1);
        chk("desc_words", dwords, 32'h3);
        @(posedge mclk);
        rchk("config reset", OFF_CONFIG, 32'h00000000);
        rchk("unmapped", 4'hC, 32'h00000000);
        // Lane 0 only: upper lanes must be left alone
        be <= 4'h1;
        access(1'b1, OFF_CONFIG, 32'hFFFFFFFF);
        be <= 4'hF;
        rchk("config lane0", OFF_CONFIG, 32'h000000FD);
        access(1'b1, OFF_CONFIG, 32'hFFFFFFFF);
        rchk("config all", OFF_CONFIG, 32'h000017FD);
        look(60);
        chk("xcvr_reset", x_rst, 32'h1);
        chk("xcvr_power_down", x_pd, 32'h1);
        chk("mii_enable", mii, 32'h1);
        chk("desc_words", dwords, 32'h4);
        chk("frag_ignore", frag_ign, 32'h1);
        chk("single_backoff", sbo, 32'h1);
        @(posedge mclk);
        rchk("reset bit kept", OFF_CONFIG, 32'h000017FD);
        rchk("status reset event", OFF_STATUS, 32'h00000004);
        rchk("status cleared", OFF_STATUS, 32'h00000000);
        access(1'b1, OFF_CONFIG, 32'h00000000);
        look(3);
        chk("desc_words", dwords, 32'h3);
        chk("frag_ignore", frag_ign, 32'h0);
        chk("xcvr_power_down", x_pd, 32'h0);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00001000);
        rchk("external sets disable", OFF_CONFIG, 32'h00001200);
        $display("test registers done");
        // Byte order of master data, register view unchanged
        mdata_in <= 32'h11223344;
        access(1'b1, OFF_CONFIG, 32'h00000001);
        rchk("config in big endian", OFF_CONFIG, 32'h00000001);
        look(3);
        chk("master data swapped", mdata_out, 32'h44332211);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00000000);
        look(3);
        chk("master data straight", mdata_out, 32'h11223344);
        @(posedge mclk);
        $display("test byte order done");
        // Parity error to SERR, with interrupt
        access(1'b1, OFF_MASK, 32'h00000007);
        kick(0);
        chk("serr", serr, 32'h1);
        look(3);
        chk("irq set", irq, 32'h1);
        @(posedge mclk);
        rchk("status serr", OFF_STATUS, 32'h00000001);
        look(3);
        chk("irq cleared", irq, 32'h0);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00000008);
        kick(0);
        chk("serr suppressed", serr, 32'h0);
        @(posedge mclk);
        rchk("status no serr", OFF_STATUS, 32'h00000000);
        $display("test parity done");
        // Excessive deferral, enabled then suppressed, interrupt masked
        access(1'b1, OFF_MASK, 32'h00000000);
        access(1'b1, OFF_CONFIG, 32'h00000000);
        kick(1);
        chk("deferral inc", def_inc, 32'h1);
        look(3);
        chk("deferral status", def_stat, 32'h1);
        chk("irq masked", irq, 32'h0);
        @(posedge mclk);
        rchk("status deferral", OFF_STATUS, 32'h00000002);
        access(1'b1, OFF_CONFIG, 32'h00000010);
        kick(1);
        chk("deferral inc off", def_inc, 32'h0);
        look(3);
        chk("deferral status off", def_stat, 32'h0);
        @(posedge mclk);
        rchk("status no deferral", OFF_STATUS, 32'h00000000);
        $display("test deferral done");
        // Boot ROM gate and bus request
        rom_req <= 1'b1;
        req_want <= 1'b1;
        access(1'b1, OFF_CONFIG, 32'h00000000);
        look(3);
        chk("rom enabled", rom_en, 32'h1);
        chk("bus request", bus_req, 32'h1);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00000004);
        look(3);
        chk("rom inhibited", rom_en, 32'h0);
        @(posedge mclk);
        // Conservative scheme holds off a new request, aggressive one does not
        access(1'b1, OFF_CONFIG, 32'h00000080);
        req_want <= 1'b0;
        look(2);
        chk("request dropped", bus_req, 32'h0);
        @(posedge mclk);
        req_want <= 1'b1;
        look(2);
        chk("conservative gap", bus_req, 32'h0);
        look(6);
        chk("conservative request", bus_req, 32'h1);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00000000);
        req_want <= 1'b0;
        look(2);
        @(posedge mclk);
        req_want <= 1'b1;
        look(2);
        chk("aggressive request", bus_req, 32'h1);
        @(posedge mclk);
        $display("test rom and request done");
        // Collision window start point, one bit time per clock
        bit_tick <= 1'b1;
        access(1'b1, OFF_CONFIG, 32'h00000000);
        kick(2);
        look(2);
        chk("window after delimiter", coll_open, 32'h1);
        look(520);
        chk("window closed", coll_open, 32'h0);
        @(posedge mclk);
        access(1'b1, OFF_CONFIG, 32'h00000020);
        kick(2);
        look(2);
        chk("delimiter ignored", coll_open, 32'h0);
        @(posedge mclk);
        kick(3);
        look(2);
        chk("window after preamble", coll_open, 32'h1);
        $display("test collision window done");
        end_of_test();
    end
endmodule
`default_nettype wire
